// ==== rtl/svr_map.svh ====
// Purpose: Timing constants for the supervisor watchdog reset block.
// Assumes: Core clock of 100 MHz.
// Notes:   Cycle counts follow from the times in ms or ns and the clock rate.
`ifndef SVR_MAP_SVH
`define SVR_MAP_SVH

// Core clock rate in MHz (period 10 ns)
`define SVR_CLK_MHZ 100
// Least reset hold period in ms; a least time, already a whole cycle count
`define SVR_RESET_HOLD_MS 150
`define SVR_RESET_HOLD_CYC (`SVR_RESET_HOLD_MS * 1000 * `SVR_CLK_MHZ)
// Watchdog period in ms; plain default, meant to be overridden
`define SVR_WATCHDOG_MS 1600
`define SVR_WATCHDOG_CYC (`SVR_WATCHDOG_MS * 1000 * `SVR_CLK_MHZ)
// Shortest watchdog input pulse that must be seen, in ns, and in cycles
`define SVR_WDI_PULSE_NS 150
`define SVR_WDI_PULSE_CYC ((`SVR_WDI_PULSE_NS * `SVR_CLK_MHZ) / 1000)
// Counter width, large enough for the default periods
`define SVR_CNT_W 28
// State encodings (Gray along hold -> timeout -> run)
`define SVR_ST_HOLD 2'h0
`define SVR_ST_TIMEOUT 2'h1
`define SVR_ST_RUN 2'h3

`endif

// ==== rtl/svr_pkg.sv ====
// Purpose: Types shared by the supervisor watchdog reset block.
// Assumes: svr_map.svh is on the include path.
// Notes:   Types only; numbers live in the map header.
`include "svr_map.svh"

package svr_pkg;

    typedef enum logic [1:0] {
        SVR_HOLD = `SVR_ST_HOLD,
        SVR_TIMEOUT = `SVR_ST_TIMEOUT,
        SVR_RUN = `SVR_ST_RUN
    } svr_state_t;

    typedef struct packed {
        logic supply_low;
        logic manual;
    } svr_cause_t;

endpackage

// ==== rtl/svr_timer.sv ====
// Purpose: Up counter with synchronous clear and a terminal flag.
// Assumes: LIMIT of at least 2 and below 2**WIDTH.
// Notes:   Saturates at LIMIT-1 so it never wraps.
`timescale 1ns/1ps

module svr_timer #(
    parameter int WIDTH = 28,
    parameter int LIMIT = 2
) (
    input wire logic core_clk, // Core clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic clear, // Return count to zero
    input wire logic enable, // Count this cycle
    output logic [WIDTH-1:0] count, // Current count
    output logic done // Count has reached LIMIT-1
);

    localparam logic [WIDTH-1:0] LAST = WIDTH'(LIMIT - 1);

    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;

    assign done = (count_reg == LAST);
    assign count = count_reg;
    assign count_next = clear ? '0 : ((enable && !done) ? count_reg + WIDTH'(1) : count_reg);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

endmodule

// ==== rtl/svr_top.sv ====
// Purpose: Supervisor that drives a processor reset from supply, manual reset and watchdog.
// Assumes: All inputs synchronous to core_clk; supply comparator given as a logic level.
// Notes:   Reset outputs are registered, one cycle behind their cause.
`timescale 1ns/1ps
`include "svr_map.svh"

module svr_top #(
    parameter int RESET_HOLD_CYCLES = `SVR_RESET_HOLD_CYC,
    parameter int WATCHDOG_CYCLES = `SVR_WATCHDOG_CYC,
    parameter int CNT_W = `SVR_CNT_W
) (
    input wire logic core_clk, // Core clock, 100 MHz
    input wire logic rst_n, // Power-on reset, active low
    input wire logic supply_low, // Supply below threshold
    input wire logic manual_reset_n, // Manual reset request, active low
    input wire logic watchdog_toggle_in, // Watchdog toggle from the processor
    output logic reset_out_n, // Processor reset, active low
    output logic reset_out, // Processor reset, active high
    output logic watchdog_expired // One-cycle pulse on watchdog expiry
);

    svr_pkg::svr_state_t state_reg;
    svr_pkg::svr_state_t state_next;
    svr_pkg::svr_cause_t cause;
    logic wdi_prev_reg;
    logic reset_n_reg;
    logic reset_reg;
    logic expired_reg;
    logic cause_any;
    logic wdi_edge;
    logic in_run;
    logic in_timeout;
    logic hold_done;
    logic wd_done;
    logic wd_expire;
    logic wd_clear;
    logic [CNT_W-1:0] hold_count;
    logic [CNT_W-1:0] wd_count;
    // Length of the current asserted stretch, watched by the hold-length check
    logic [CNT_W-1:0] low_run_reg;

    // Reset is released only in the run state
    function automatic logic is_released(input svr_pkg::svr_state_t s);
        return (s == svr_pkg::SVR_RUN);
    endfunction

    // The pin's pull-up belongs to the pad; a floating input arrives here as high
    assign cause.supply_low = supply_low;
    assign cause.manual = !manual_reset_n;
    assign cause_any = cause.supply_low || cause.manual;
    assign in_run = is_released(state_reg);
    assign in_timeout = (state_reg == svr_pkg::SVR_TIMEOUT);
    // Edge on either polarity; a single-cycle pulse yields two edges
    assign wdi_edge = watchdog_toggle_in ^ wdi_prev_reg;
    assign wd_expire = in_run && wd_done && !wdi_edge && !cause_any;
    // Expiry clears too, so the timer reads zero from the first cycle of reset
    assign wd_clear = !in_run || wdi_edge || cause_any || wd_expire;

    svr_timer #(
        .WIDTH(CNT_W),
        .LIMIT(RESET_HOLD_CYCLES)
    ) u_hold (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clear(!in_timeout || cause_any),
        .enable(in_timeout),
        .count(hold_count),
        .done(hold_done)
    );

    svr_timer #(
        .WIDTH(CNT_W),
        .LIMIT(WATCHDOG_CYCLES)
    ) u_wdog (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clear(wd_clear),
        .enable(in_run),
        .count(wd_count),
        .done(wd_done)
    );

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            svr_pkg::SVR_HOLD: begin
                if (!cause_any) begin
                    state_next = svr_pkg::SVR_TIMEOUT;
                end
            end
            svr_pkg::SVR_TIMEOUT: begin
                if (cause_any) begin
                    state_next = svr_pkg::SVR_HOLD;
                end else if (hold_done) begin
                    state_next = svr_pkg::SVR_RUN;
                end
            end
            svr_pkg::SVR_RUN: begin
                if (cause_any) begin
                    state_next = svr_pkg::SVR_HOLD;
                end else if (wd_expire) begin
                    state_next = svr_pkg::SVR_TIMEOUT;
                end
            end
            default: begin
                state_next = svr_pkg::SVR_HOLD;
            end
        endcase
    end

    // Power-up starts in hold with reset asserted and timers cleared
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= svr_pkg::SVR_HOLD;
            reset_n_reg <= 1'b0;
            reset_reg <= 1'b1;
            expired_reg <= 1'b0;
            wdi_prev_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            reset_n_reg <= is_released(state_next);
            reset_reg <= !is_released(state_next);
            expired_reg <= wd_expire;
            wdi_prev_reg <= watchdog_toggle_in;
        end
    end

    assign reset_out_n = reset_n_reg;
    assign reset_out = reset_reg;
    assign watchdog_expired = expired_reg;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    a_reset_inverse: assert property (reset_out == !reset_out_n)
        else $error("reset outputs not complementary");

    a_cause_low_out: assert property (cause_any |=> !reset_out_n)
        else $error("active-low reset not asserted on cause");

    a_cause_high_out: assert property (cause_any |=> reset_out)
        else $error("active-high reset not asserted on cause");

    a_release_after_hold: assert property ($rose(reset_out_n) |->
        ($past(hold_count) == CNT_W'(RESET_HOLD_CYCLES - 1)) && $past(in_timeout) && !$past(cause_any))
        else $error("reset released before full hold period");

    a_manual_holds_reset: assert property (!manual_reset_n ##1 manual_reset_n |->
        !reset_out_n ##1 !reset_out_n)
        else $error("reset not held after manual release");

    a_wdog_expiry_reset: assert property (in_run && wd_count == CNT_W'(WATCHDOG_CYCLES - 1)
        && !wdi_edge && !cause_any |=> watchdog_expired && !reset_out_n && in_timeout && hold_count == '0)
        else $error("watchdog expiry did not trigger reset");

    a_wdog_edge_clear: assert property ($changed(watchdog_toggle_in) || !manual_reset_n |=>
        wd_count == '0)
        else $error("watchdog timer not cleared");

    a_wdog_stopped: assert property (!reset_out_n |-> wd_count == '0)
        else $error("watchdog counted during reset");

    a_wdog_resume: assert property (in_run && !wdi_edge && !cause_any && !wd_done |=>
        wd_count == $past(wd_count) + CNT_W'(1))
        else $error("watchdog did not count while running");

    a_short_pulse_clear: assert property (in_run && $changed(watchdog_toggle_in) ##1
        $changed(watchdog_toggle_in) |=> wd_count == '0)
        else $error("short watchdog pulse missed");

    a_expired_pulse: assert property (watchdog_expired |=> !watchdog_expired)
        else $error("watchdog expiry flag longer than one cycle");

    a_expiry_high_out: assert property (wd_expire |=> reset_out)
        else $error("active-high reset not asserted on expiry");

    a_stays_released: assert property (reset_out_n && !cause_any && !wd_expire |=> reset_out_n)
        else $error("reset asserted without a cause");

    a_cause_to_hold: assert property (cause_any |=> state_reg == svr_pkg::SVR_HOLD)
        else $error("cause did not hold reset");

    a_hold_restart: assert property (in_timeout && cause_any |=> !reset_out_n && hold_count == '0)
        else $error("cause during hold did not restart it");

    a_hold_count_step: assert property (in_timeout && !cause_any && !hold_done |=>
        hold_count == $past(hold_count) + CNT_W'(1))
        else $error("hold timer did not count");

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_run_reg <= '0;
        end else if (reset_out_n) begin
            low_run_reg <= '0;
        end else if (low_run_reg != '1) begin
            low_run_reg <= low_run_reg + CNT_W'(1);
        end
    end

    a_hold_length: assert property ($rose(reset_out_n) |->
        $past(low_run_reg) >= CNT_W'(RESET_HOLD_CYCLES - 1))
        else $error("reset asserted for less than the hold period");

    c_manual_reset: cover property (!manual_reset_n ##1 manual_reset_n);
    c_wdog_expiry: cover property (watchdog_expired);
    c_release: cover property ($rose(reset_out_n));
    c_supply_drop: cover property (in_run ##1 supply_low);
    c_hold_restart: cover property (in_timeout && cause_any);

endmodule

// ==== verification/svr_host_model.sv ====
// Purpose: Host processor that feeds the supervisor watchdog.
// Assumes: Drives shortly after each rising edge of core_clk.
// Notes:   Level toggle every GAP+1 cycles, or one-cycle pulse every GAP+2 cycles.
`timescale 1ns/1ps

module svr_host_model #(
    parameter int GAP = 25
) (
    input wire logic core_clk, // Core clock
    input wire logic reset_out_n, // Reset from the supervisor
    input wire logic alive, // Software runs normally
    input wire logic pulse_mode, // Short pulse instead of toggle
    output logic watchdog_toggle_in // Watchdog input
);
    int gap_cnt = 0;
    logic pulse_back = 1'b0;
    logic wdi_level = 1'b0;
    assign watchdog_toggle_in = wdi_level;
    always @(posedge core_clk) begin
        #1;
        if (!reset_out_n || !alive) begin
            gap_cnt = 0; // Held in reset or hung: input stays put
        end else if (pulse_back) begin
            pulse_back = 1'b0;
            wdi_level = ~wdi_level;
        end else if (gap_cnt == GAP) begin
            gap_cnt = 0;
            pulse_back = pulse_mode;
            wdi_level = ~wdi_level;
        end else begin
            gap_cnt = gap_cnt + 1;
        end
    end
endmodule

// ==== verification/tb.sv ====
// Purpose: Self-checking bench for the supervisor watchdog reset block.
// Assumes: Short hold and watchdog periods set by parameter.
// Notes:   Spans run from the expected count, or one below, to two cycles above it.
`timescale 1ns/1ps

module tb;
    localparam int HOLD = 20;
    localparam int WD = 30;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic supply_low = 1'b0;
    logic manual_reset_n = 1'b1;
    logic host_alive = 1'b1;
    logic host_pulse = 1'b0;
    logic watchdog_toggle_in;
    logic reset_out_n;
    logic reset_out;
    logic watchdog_expired;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;

    svr_top #(.RESET_HOLD_CYCLES(HOLD), .WATCHDOG_CYCLES(WD)) svr_top_i (.core_clk(core_clk), .rst_n(rst_n),
        .supply_low(supply_low), .manual_reset_n(manual_reset_n), .watchdog_toggle_in(watchdog_toggle_in),
        .reset_out_n(reset_out_n), .reset_out(reset_out), .watchdog_expired(watchdog_expired));
    svr_host_model #(.GAP(WD - 5)) svr_host_model_i (.core_clk(core_clk), .reset_out_n(reset_out_n),
        .alive(host_alive), .pulse_mode(host_pulse), .watchdog_toggle_in(watchdog_toggle_in));

    initial begin
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            failures = failures + 1;
            results();
        end
    end

    task automatic check(string what, logic exp, logic got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %0b seen %0b", what, exp, got);
        end
    endtask
    task automatic check_span(string what, int lo, int hi, int got);
        samples_checked++;
        if (got < lo || got > hi) begin
            failures++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    task automatic step();
        @(posedge core_clk);
        #1;
        check("reset_inverse", ~reset_out_n, reset_out);
    endtask
    task automatic hold_span(output int k);
        k = 0;
        while (reset_out_n !== 1'b1 && k < 100) begin
            step();
            k++;
        end
    endtask
    task automatic t_cause(bit sup);
        if (sup) supply_low = 1'b1;
        else manual_reset_n = 1'b0;
        step();
        step();
        check("reset_low", 1'b0, reset_out_n);
        check("reset_high", 1'b1, reset_out);
        repeat (HOLD + 10) step();
        check("held_in_cause", 1'b0, reset_out_n);
        supply_low = 1'b0;
        manual_reset_n = 1'b1;
        hold_span(n);
        check_span("cause_hold", HOLD, HOLD + 2, n);
        $display("Test cause %0d done", sup);
    endtask
    task automatic t_fed(bit pulse);
        host_pulse = pulse;
        repeat (3 * WD) begin
            step();
            check("fed_no_reset", 1'b1, reset_out_n);
            check("fed_no_expiry", 1'b0, watchdog_expired);
        end
        $display("Test fed %0d done", pulse);
    endtask
    task automatic t_starve();
        host_alive = 1'b0;
        repeat (2) begin
            n = 0;
            while (watchdog_expired !== 1'b1 && n < WD + 10) begin
                step();
                n++;
            end
            check_span("expiry_time", WD - 1, WD + 2, n);
            step();
            check("expiry_reset", 1'b0, reset_out_n);
            check("expiry_reset_high", 1'b1, reset_out);
            check("expiry_pulse", 1'b0, watchdog_expired);
            hold_span(n);
            check_span("expiry_hold", HOLD - 1, HOLD + 2, n);
        end
        host_alive = 1'b1;
        $display("Test starve done");
    endtask
    task automatic t_restart();
        manual_reset_n = 1'b0;
        step();
        manual_reset_n = 1'b1;
        repeat (5) step();
        supply_low = 1'b1;
        step();
        supply_low = 1'b0;
        check("restart_held", 1'b0, reset_out_n);
        hold_span(n);
        check_span("restart_hold", HOLD, HOLD + 2, n);
        $display("Test restart done");
    endtask
    task automatic results();
        $display("Checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        step();
        check("power_up_reset", 1'b0, reset_out_n);
        hold_span(n);
        check_span("power_hold", HOLD, HOLD + 2, n);
        t_fed(1'b0);
        t_fed(1'b1);
        t_cause(1'b0);
        t_cause(1'b1);
        t_starve();
        t_restart();
        results();
    end
endmodule
